//--- core/alert_mask_pkg.sv
// Package with selector codes, field layouts and timing for the alert mask bank.
package alert_mask_pkg;

  // Shared mask command code and the page value that means all phases.
  localparam logic [7:0] MASK_CMD_CODE  = 8'h1b;
  localparam logic [7:0] PAGE_ALL       = 8'hff;

  // Status-group selector bytes.
  localparam logic [7:0] SEL_TEMP       = 8'h7d;
  localparam logic [7:0] SEL_COMM       = 8'h7e;
  localparam logic [7:0] SEL_OTHER      = 8'h7f;
  localparam logic [7:0] SEL_VENDOR     = 8'h80;

  // Writable bits of each group; all other bits read as zero.
  localparam logic [7:0] TEMP_WR_BITS   = 8'hc0;
  localparam logic [7:0] COMM_WR_BITS   = 8'hf2;
  localparam logic [7:0] VENDOR_WR_BITS = 8'hce;

  // The other group is hard-wired with bit 0 set.
  localparam logic [7:0] OTHER_FIXED    = 8'h01;

  // Field positions.
  localparam int OVERTEMP_FAULT_BIT     = 7;
  localparam int OVERTEMP_WARN_BIT      = 6;
  localparam int SELF_CHECK_BIT         = 6;
  localparam int SYNC_FAULT_BIT         = 1;

  // Cycles from a taken request to its answer.
  localparam int ANSWER_LATENCY         = 1;

  // Register bus command kinds.
  typedef enum logic [1:0] {
    REQ_IDLE  = 2'b00,
    REQ_WRITE = 2'b01,
    REQ_READ  = 2'b10
  } req_kind_t;

  // One request from the command decoder.
  typedef struct packed {
    req_kind_t  kind;
    logic [7:0] page;
    logic [7:0] sel;
    logic [7:0] data;
  } mask_req_t;

  // The four mask bytes as a group.
  typedef struct packed {
    logic [7:0] temp;
    logic [7:0] comm;
    logic [7:0] other;
    logic [7:0] vendor;
  } mask_set_t;

endpackage

//--- core/alert_mask_bank.sv
// Alert mask bank: four status-group masks behind one command code.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE_01: mask bit zero lets its status bit raise alert; one blocks it.
// RULE_02: temperature mask writes bits 7 and 6; bits 5:0 read zero.
// RULE_03: selector 7Eh picks comm mask; bits 7,6,5,4,1 write, others zero.
// RULE_04: comm mask answers only page FFh; other pages are refused.
// RULE_05: selector 7Fh picks other mask; bits 7:1 read zero.
// RULE_06: other mask bit 0 is fixed at one, first-alerter never alerts.
// RULE_07: selector 80h picks vendor mask; bits 7,6,3,2,1 write, others zero.
// RULE_08: unmasked self-check may raise alert during power-up supply ramp.
// RULE_09: unmasked sync fault may pulse alert when the stack is enabled.
// RULE_10: host writes a word: low byte selector, high byte new mask.
// RULE_11: host reads with process call: selector in, one mask byte out.
// RULE_12: alert is any status bit set with mask zero; writes act at once.
module alert_mask_bank (
  // Clock and reset.
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_n_i,
  // Power-up mask values from nonvolatile memory, loaded on request.
  input  wire logic                   nvm_load_i,
  input  wire alert_mask_pkg::mask_set_t nvm_masks_i,
  // Command port from the bus protocol engine.
  input  wire alert_mask_pkg::mask_req_t req_i,
  // Answer to the command port.
  output logic                        rd_valid_o,
  output logic [7:0]                  rd_data_o,
  output logic                        req_refused_o,
  // Status bits of each group.
  input  wire alert_mask_pkg::mask_set_t status_i,
  // Alert request towards the pin driver, active high.
  output logic                        alert_o,
  // Current vendor mask shown to the rest of the device.
  output logic [7:0]                  vendor_mask_o
);

  // Mask state.
  alert_mask_pkg::mask_set_t masks_ff;
  alert_mask_pkg::mask_set_t nxt_masks;
  // Answer state.
  logic                      rd_valid_ff;
  logic                      nxt_rd_valid;
  logic [7:0]                rd_data_ff;
  logic [7:0]                nxt_rd_data;
  logic                      refused_ff;
  logic                      nxt_refused;
  logic                      alert_ff;
  logic                      nxt_alert;
  // Decode helpers.
  logic                      sel_ok;
  logic                      page_ok;
  logic [7:0]                sel_value;
  logic [7:0]                eff_temp;
  logic [7:0]                eff_comm;
  logic [7:0]                eff_vendor;

  // Selector decode and read value of the addressed group.
  always_comb begin
    sel_ok    = 1'b1;
    page_ok   = 1'b1;
    sel_value = 8'h00;
    if (req_i.sel == alert_mask_pkg::SEL_TEMP) begin
      sel_value = masks_ff.temp;                         // see RULE_02
    end else if (req_i.sel == alert_mask_pkg::SEL_COMM) begin
      sel_value = masks_ff.comm;                         // see RULE_03
      page_ok   = (req_i.page == alert_mask_pkg::PAGE_ALL); // see RULE_04
    end else if (req_i.sel == alert_mask_pkg::SEL_OTHER) begin
      sel_value = alert_mask_pkg::OTHER_FIXED;           // see RULE_05
    end else if (req_i.sel == alert_mask_pkg::SEL_VENDOR) begin
      sel_value = masks_ff.vendor;                       // see RULE_07
    end else begin
      sel_ok    = 1'b0;
    end
  end

  // Mask writes, NVM load and read answers.
  always_comb begin
    nxt_masks       = masks_ff;
    nxt_rd_valid    = 1'b0;
    nxt_rd_data     = rd_data_ff;
    nxt_refused     = 1'b0;
    nxt_masks.other = alert_mask_pkg::OTHER_FIXED;       // see RULE_06
    if (nvm_load_i) begin
      nxt_masks.temp   = nvm_masks_i.temp & alert_mask_pkg::TEMP_WR_BITS;
      nxt_masks.comm   = nvm_masks_i.comm & alert_mask_pkg::COMM_WR_BITS;
      nxt_masks.vendor = nvm_masks_i.vendor
                         & alert_mask_pkg::VENDOR_WR_BITS;
    end else if (req_i.kind == alert_mask_pkg::REQ_WRITE) begin
      if (!sel_ok || !page_ok) begin
        nxt_refused = 1'b1;                              // see RULE_04
      end else if (req_i.sel == alert_mask_pkg::SEL_TEMP) begin
        nxt_masks.temp = req_i.data
                         & alert_mask_pkg::TEMP_WR_BITS;  // see RULE_10
      end else if (req_i.sel == alert_mask_pkg::SEL_COMM) begin
        nxt_masks.comm = req_i.data
                         & alert_mask_pkg::COMM_WR_BITS;  // see RULE_03
      end else if (req_i.sel == alert_mask_pkg::SEL_VENDOR) begin
        nxt_masks.vendor = req_i.data
                           & alert_mask_pkg::VENDOR_WR_BITS; // see RULE_07
      end
    end else if (req_i.kind == alert_mask_pkg::REQ_READ) begin
      if (!sel_ok || !page_ok) begin
        nxt_refused = 1'b1;
      end else begin
        nxt_rd_valid = 1'b1;                             // see RULE_11
        nxt_rd_data  = sel_value;
      end
    end
  end

  // Effective masks follow writes in the same cycle so they act at once.
  always_comb begin
    eff_temp   = nxt_masks.temp;
    eff_comm   = nxt_masks.comm;
    eff_vendor = nxt_masks.vendor;
    // A status bit alerts only where its mask is zero; self-check and
    // sync-fault bits may thus alert at power-up or stack enable.
    nxt_alert  = |(status_i.temp & ~eff_temp)            // see RULE_01
               | |(status_i.comm & ~eff_comm)            // see RULE_12
               | |(status_i.other
                   & ~alert_mask_pkg::OTHER_FIXED)       // see RULE_06
               | |(status_i.vendor & ~eff_vendor);       // see RULE_08 RULE_09
  end

  // Register all state; masks reset with every writable bit set until NVM load.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      masks_ff    <= '{temp: alert_mask_pkg::TEMP_WR_BITS,
                       comm: alert_mask_pkg::COMM_WR_BITS,
                       other: alert_mask_pkg::OTHER_FIXED,
                       vendor: alert_mask_pkg::VENDOR_WR_BITS};
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= 8'h00;
      refused_ff  <= 1'b0;
      alert_ff    <= 1'b0;
    end else begin
      masks_ff    <= nxt_masks;
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff  <= nxt_rd_data;
      refused_ff  <= nxt_refused;
      alert_ff    <= nxt_alert;
    end
  end

  // Outputs straight from flip-flops.
  assign rd_valid_o    = rd_valid_ff;
  assign rd_data_o     = rd_data_ff;
  assign req_refused_o = refused_ff;
  assign alert_o       = alert_ff;
  assign vendor_mask_o = masks_ff.vendor;

  // The other group holds one fixed value, first-alerter always masked.
  a_other_fixed: assert property ( // see RULE_06
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    masks_ff.other == 8'h01)
    else $error("other mask not fixed");

  // Unsupported temperature bits stay zero whatever is written.
  a_temp_zero: assert property ( // see RULE_02
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    masks_ff.temp[5:0] == 6'h00)
    else $error("temp low bits set");

  // Unsupported comm bits 3, 2 and 0 stay zero.
  a_comm_zero: assert property ( // see RULE_03
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (masks_ff.comm & 8'h0d) == 8'h00)
    else $error("comm rsvd set");

  // Unsupported vendor bits 5, 4 and 0 stay zero.
  a_vendor_zero: assert property ( // see RULE_07
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (masks_ff.vendor & 8'h31) == 8'h00)
    else $error("vendor rsvd");

  // A comm access on one phase is refused and leaves the mask alone.
  a_comm_page: assert property ( // see RULE_04
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (req_i.kind != alert_mask_pkg::REQ_IDLE && req_i.sel == 8'h7e
     && req_i.page != 8'hff && !nvm_load_i)
    |=> (refused_ff && !rd_valid_ff && $stable(masks_ff.comm)))
    else $error("comm page not refused");

  // A temperature write lands at once with only its writable bits.
  a_write_lands: assert property ( // see RULE_10
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (req_i.kind == alert_mask_pkg::REQ_WRITE && req_i.sel == 8'h7d
     && !nvm_load_i)
    |=> masks_ff.temp == ($past(req_i.data) & 8'hc0))
    else $error("temp write lost");

  // A vendor write lands at once with only its writable bits.
  a_vendor_lands: assert property ( // see RULE_07
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (req_i.kind == alert_mask_pkg::REQ_WRITE && req_i.sel == 8'h80
     && !nvm_load_i)
    |=> masks_ff.vendor == ($past(req_i.data) & 8'hce))
    else $error("vendor write lost");

  // A read of the other group answers its fixed value next cycle.
  a_read_answer: assert property ( // see RULE_11
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (req_i.kind == alert_mask_pkg::REQ_READ && req_i.sel == 8'h7f
     && !nvm_load_i)
    |=> (rd_valid_ff && rd_data_o == 8'h01))
    else $error("other read wrong");

  // A read of an unknown selector is refused and answers no data.
  a_sel_refused: assert property ( // see RULE_11
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (req_i.kind == alert_mask_pkg::REQ_READ && !nvm_load_i
     && (req_i.sel < 8'h7d || req_i.sel > 8'h80))
    |=> (refused_ff && !rd_valid_ff))
    else $error("unknown selector taken");

  // Alert only follows a status bit whose mask was clear.
  a_alert_cause: assert property ( // see RULE_12
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    alert_ff |-> $past((|(status_i.temp & ~nxt_masks.temp))
      || (|(status_i.comm & ~nxt_masks.comm))
      || (|(status_i.other & 8'hfe))
      || (|(status_i.vendor & ~nxt_masks.vendor))))
    else $error("alert without cause");

  // Unmasked self-check status raises alert on the next edge.
  a_alert_raise: assert property ( // see RULE_08
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (status_i.vendor[alert_mask_pkg::SELF_CHECK_BIT]
     && !nxt_masks.vendor[alert_mask_pkg::SELF_CHECK_BIT]) |=> alert_ff)
    else $error("self check alert missed");

  // Unmasked sync-fault status raises alert on the next edge.
  a_sync_alert: assert property ( // see RULE_09
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (status_i.vendor[alert_mask_pkg::SYNC_FAULT_BIT]
     && !nxt_masks.vendor[alert_mask_pkg::SYNC_FAULT_BIT]) |=> alert_ff)
    else $error("sync fault alert missed");

  // With no status bit set there is no alert.
  a_alert_mask: assert property ( // see RULE_01
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (status_i == '0) |=> !alert_ff)
    else $error("alert with no status");

endmodule

`default_nettype wire

//--- testbench/mask_host_model.sv
// Host model that issues mask write and read requests to the bank.
`timescale 1ns/1ps
`default_nettype none
module mask_host_model (
  // Request towards the bank.
  output var alert_mask_pkg::mask_req_t req_o
);
  // Starts idle, so no request is made before reset is released.
  initial begin
    req_o = '0;
  end

  // Word write carries selector and mask; process call carries selector.
  task automatic send(input logic [1:0] k, input logic [7:0] pg,
                      input logic [7:0] sl, input logic [7:0] dt);
    req_o = '{alert_mask_pkg::req_kind_t'(k),
              pg, sl, dt};
  endtask
endmodule
`default_nettype wire

//--- testbench/alert_mask_bank_tb.sv
// Self-checking bench for the alert mask bank.
`timescale 1ns/1ps
`default_nettype none
module alert_mask_bank_tb;
  typedef struct packed {
    logic [1:0] k; logic [7:0] pg; logic [7:0] sl; logic [7:0] dt;
    logic [31:0] st; logic v; logic r; logic [7:0] d; logic a;
  } row_t;
  logic clk_sys_i, rst_n_i, nvm_load_i, rd_valid_o, req_refused_o, alert_o;
  logic [7:0] rd_data_o, vendor_mask_o;
  alert_mask_pkg::mask_set_t nvm_masks_i, status_i;
  alert_mask_pkg::mask_req_t req_i;
  int num_errors = 0;
  int compares = 0;
  // Writes and reads back to back, one per cycle, with status per row.
  row_t rows [16] = '{
    '{2'h2,8'hff,8'h7d,8'h0,32'h0,1'b1,1'b0,8'hc0,1'b0},
    '{2'h1,8'hff,8'h7d,8'h7f,32'h80000000,1'b0,1'b0,8'h0,1'b1},
    '{2'h2,8'hff,8'h7d,8'h0,32'h40000000,1'b1,1'b0,8'h40,1'b0},
    '{2'h1,8'hff,8'h7e,8'h0,32'h00020000,1'b0,1'b0,8'h0,1'b1},
    '{2'h1,8'hff,8'h7e,8'hff,32'h00020000,1'b0,1'b0,8'h0,1'b0},
    '{2'h2,8'hff,8'h7e,8'h0,32'h0,1'b1,1'b0,8'hf2,1'b0},
    '{2'h1,8'h10,8'h7e,8'h0,32'h00f20000,1'b0,1'b1,8'h0,1'b0},
    '{2'h2,8'h10,8'h7e,8'h0,32'h0,1'b0,1'b1,8'h0,1'b0},
    '{2'h2,8'hff,8'h7e,8'h0,32'h0,1'b1,1'b0,8'hf2,1'b0},
    '{2'h1,8'hff,8'h7f,8'h0,32'h00000100,1'b0,1'b0,8'h0,1'b0},
    '{2'h2,8'hff,8'h7f,8'h0,32'h00000100,1'b1,1'b0,8'h01,1'b0},
    '{2'h1,8'hff,8'h80,8'h0,32'h00000042,1'b0,1'b0,8'h0,1'b1},
    '{2'h2,8'hff,8'h80,8'h0,32'h0,1'b1,1'b0,8'h00,1'b0},
    '{2'h1,8'hff,8'h80,8'hff,32'h00000042,1'b0,1'b0,8'h0,1'b0},
    '{2'h2,8'hff,8'h80,8'h0,32'h0,1'b1,1'b0,8'hce,1'b0},
    '{2'h2,8'hff,8'h55,8'h0,32'h0,1'b0,1'b1,8'h0,1'b0}};

  mask_host_model u_mask_host_model (.req_o(req_i));
  alert_mask_bank u_alert_mask_bank (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .nvm_load_i(nvm_load_i), .nvm_masks_i(nvm_masks_i), .req_i(req_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .req_refused_o(req_refused_o), .status_i(status_i), .alert_o(alert_o),
    .vendor_mask_o(vendor_mask_o));

  // Compares one flag and reports a mismatch.
  task automatic chk_bit(input logic e, input logic g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Compares one byte and reports a mismatch.
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Clock of 25 ns.
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Cuts a hang short.
  initial begin
    #20us;
    num_errors++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    rst_n_i = 1'b0;
    nvm_load_i = 1'b0;
    nvm_masks_i = '0;
    status_i = '0;
    repeat (8) @(negedge clk_sys_i);
    chk_bit(1'b0, alert_o);
    chk_bit(1'b0, rd_valid_o);
    chk_bit(1'b0, req_refused_o);
    chk_byte(8'h00, rd_data_o);
    chk_byte(8'hce, vendor_mask_o);
    rst_n_i = 1'b1;
    for (int i = 0; i <= 16; i++) begin
      @(negedge clk_sys_i);
      if (i > 0) begin
        chk_bit(rows[i-1].v, rd_valid_o);
        chk_bit(rows[i-1].r, req_refused_o);
        chk_bit(rows[i-1].a, alert_o);
        if (rows[i-1].v) chk_byte(rows[i-1].d, rd_data_o);
      end
      if (i < 16) begin
        u_mask_host_model.send(rows[i].k, rows[i].pg, rows[i].sl, rows[i].dt);
        status_i = rows[i].st;
      end else begin
        u_mask_host_model.send(2'h0, 8'h0, 8'h0, 8'h0);
      end
    end
    // Memory load opens the masks, drops fixed bits, beats a same write.
    @(negedge clk_sys_i);
    nvm_load_i = 1'b1;
    nvm_masks_i = 32'h0000fe31;
    status_i = 32'h00000080;
    u_mask_host_model.send(2'h1, 8'hff, 8'h80, 8'hff);
    @(negedge clk_sys_i);
    nvm_load_i = 1'b0;
    u_mask_host_model.send(2'h0, 8'h0, 8'h0, 8'h0);
    chk_byte(8'h00, vendor_mask_o);
    chk_bit(1'b0, req_refused_o);
    @(negedge clk_sys_i);
    chk_bit(1'b1, alert_o);
    // Reset in mid-run sets every writable mask bit again at once.
    rst_n_i = 1'b0;
    #1;
    chk_bit(1'b0, alert_o);
    chk_byte(8'hce, vendor_mask_o);
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    // A read at the first edge after release sees the reset mask.
    u_mask_host_model.send(2'h2, 8'hff, 8'h80, 8'h0);
    @(negedge clk_sys_i);
    u_mask_host_model.send(2'h0, 8'h0, 8'h0, 8'h0);
    chk_bit(1'b1, rd_valid_o);
    chk_byte(8'hce, rd_data_o);
    chk_bit(1'b0, alert_o);
    give_verdict();
  end
endmodule
`default_nettype wire
